// *** src/line_buffer_pkg.sv ***
// Shared constants and carrier types for the serial line delay buffer
package line_buffer_pkg;

   // Byte width of each port
   localparam int BYTE_W = 8;
   // Static front region size in bytes
   localparam int STATIC_BYTES = 8;
   // Rows per dynamic subarray
   localparam int SUB_ROWS = 71;
   // Byte columns per dynamic row
   localparam int ROW_COLS = 8;
   // Number of dynamic subarrays
   localparam int SUB_COUNT = 2;
   // Dynamic bytes per subarray
   localparam int SUB_BYTES = SUB_ROWS * ROW_COLS;
   // Total dynamic bytes
   localparam int DYN_BYTES = SUB_COUNT * SUB_BYTES;
   // Pointer width, enough for the largest line
   localparam int PTR_W = 11;
   // Line lengths of the two configurations
   localparam logic [PTR_W-1:0] LEN_SHORT = 11'h38e;
   localparam logic [PTR_W-1:0] LEN_LONG = 11'h46f;
   // Pointer value after a clear
   localparam logic [PTR_W-1:0] PTR_ZERO = 11'h000;
   // Pointer step per transfer
   localparam logic [PTR_W-1:0] PTR_STEP = 11'h001;
   // Static region span in pointer units
   localparam logic [PTR_W-1:0] STATIC_END = 11'h008;

   // Write-side request carrier
   typedef struct packed
   {
      logic clear_n;
      logic enable_n;
      logic [BYTE_W-1:0] data;
   } wr_req_t;

   // Read-side request carrier
   typedef struct packed
   {
      logic clear_n;
      logic enable_n;
   } rd_req_t;

   // Selector position of one port
   typedef struct packed
   {
      logic in_static;
      logic bank;
      logic [ROW_COLS-1:0] col_hot;
      logic [SUB_ROWS-1:0] row_hot;
      logic [$clog2(STATIC_BYTES)-1:0] static_idx;
   } sel_pos_t;

endpackage : line_buffer_pkg

// *** src/port_sync.sv ***
// Two-flop synchroniser for a group of port signals
`timescale 1ns/100ps
module port_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Raw and settled values
   input wire logic [WIDTH-1:0] raw_i,
   output logic [WIDTH-1:0] sync_o
);

   // First stage, read only by the second stage
   logic [WIDTH-1:0] meta;

   ////////////////////////////////////////////////////////////////////////
   // Two flip-flops in series
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta <= INIT;
         sync_o <= INIT;
      end
      else
      begin
         meta <= raw_i;
         sync_o <= meta;
      end
   end

endmodule : port_sync

// *** src/ring_selector.sv ***
// One-hot ring shift register used as a row or column selector
`timescale 1ns/100ps
module ring_selector #(
   parameter int N = 8
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Controls
   input wire logic clear_i,
   input wire logic step_i,
   // One-hot position
   output logic [N-1:0] hot_o
);

   // First position value
   localparam logic [N-1:0] FIRST = {{(N-1){1'b0}}, 1'b1};

   ////////////////////////////////////////////////////////////////////////
   // Ring shift; clear parks on the first position
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         hot_o <= FIRST;
      end
      else if (clear_i)
      begin
         hot_o <= FIRST; // R16
      end
      else if (step_i)
      begin
         hot_o <= {hot_o[N-2:0], hot_o[N-1]}; // R21
      end
   end

endmodule : ring_selector

// *** src/serial_line_delay_buffer.sv ***
// Serial-access byte line buffer with independent write and read ports
`timescale 1ns/100ps
// Overview of operation
// R1 - Pointer clears zero each address independently
// R2 - Clears sampled on own port clock edge
// R3 - Each enabled cycle moves one word, pointer+1
// R4 - Short configuration wraps after address 909
// R5 - Long configuration wraps after address 1134
// R6 - Input enable high: no store, address held
// R7 - Output enable high: no read, outputs released
// R8 - Eight static bytes then dynamic region
// R9 - Separate concurrent write and read paths
// R10 - Two subarrays of 71 rows, 8 bytes
// R11 - First 8 accesses after clear hit static
// R12 - Rows alternate subarray 1 then subarray 2
// R13 - Dynamic address parked during static accesses
// R14 - Next row preselected ahead of access
// R15 - Separate row selectors per port path
// R16 - Selectors one-hot, first position on clear
// R17 - Column selector steps once per transfer
// R18 - Row selector steps on subarray crossing
// R19 - Write touches only selected row and column
// R20 - Address advances after transfer, enable low
// R21 - Selectors are rings returning to first
// R22 - Host keeps read trailing write; no flags
module serial_line_delay_buffer #(
   parameter bit LONG_LINE = 1'b0
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Write port pins
   input wire logic input_clock_i,
   input wire logic input_pointer_clear_n_i,
   input wire logic input_port_enable_n_i,
   input wire logic [line_buffer_pkg::BYTE_W-1:0] byte_in_i,
   // Read port pins
   input wire logic output_clock_i,
   input wire logic output_pointer_clear_n_i,
   input wire logic output_port_enable_n_i,
   // Read data and its drive enable
   output logic [line_buffer_pkg::BYTE_W-1:0] byte_out_o,
   output logic byte_out_oe_o
);

   // Line length of this configuration
   localparam logic [line_buffer_pkg::PTR_W-1:0] LINE_LEN =
      LONG_LINE ? line_buffer_pkg::LEN_LONG : line_buffer_pkg::LEN_SHORT;
   // Synchroniser width for the write group (clock + carrier)
   localparam int WSYNC_W = 1 + $bits(line_buffer_pkg::wr_req_t);
   localparam int RSYNC_W = 1 + $bits(line_buffer_pkg::rd_req_t);
   localparam int SIDX_W = $clog2(line_buffer_pkg::STATIC_BYTES);
   localparam int CIDX_W = $clog2(line_buffer_pkg::ROW_COLS);
   localparam int RIDX_W = $clog2(line_buffer_pkg::SUB_ROWS);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Next pointer with wrap at the line end
   function automatic logic [line_buffer_pkg::PTR_W-1:0] next_ptr_f(
      input logic [line_buffer_pkg::PTR_W-1:0] p);
      if (p == LINE_LEN - line_buffer_pkg::PTR_STEP)
         next_ptr_f = line_buffer_pkg::PTR_ZERO; // R4 R5
      else
         next_ptr_f = p + line_buffer_pkg::PTR_STEP; // R3
   endfunction : next_ptr_f

   // Index of the high bit of a column one-hot vector
   function automatic logic [CIDX_W-1:0] col_idx_f(
      input logic [line_buffer_pkg::ROW_COLS-1:0] hot);
      col_idx_f = '0;
      for (int i = 0; i < line_buffer_pkg::ROW_COLS; i++)
         if (hot[i])
            col_idx_f = CIDX_W'(i);
   endfunction : col_idx_f

   // Index of the high bit of a row one-hot vector
   function automatic logic [RIDX_W-1:0] row_idx_f(
      input logic [line_buffer_pkg::SUB_ROWS-1:0] hot);
      row_idx_f = '0;
      for (int i = 0; i < line_buffer_pkg::SUB_ROWS; i++)
         if (hot[i])
            row_idx_f = RIDX_W'(i);
   endfunction : row_idx_f

   // Position carrier from a pointer and its two rings; the bank bit
   // flips on every row boundary once past the static bytes
   function automatic line_buffer_pkg::sel_pos_t pos_f(
      input logic [line_buffer_pkg::PTR_W-1:0] p,
      input logic [line_buffer_pkg::ROW_COLS-1:0] col,
      input logic [line_buffer_pkg::SUB_ROWS-1:0] row);
      line_buffer_pkg::sel_pos_t pos;
      pos.in_static = (p < line_buffer_pkg::STATIC_END); // R11 R13
      pos.bank = ~p[CIDX_W]; // R12
      pos.col_hot = col;
      pos.row_hot = row;
      pos.static_idx = p[SIDX_W-1:0];
      pos_f = pos;
   endfunction : pos_f

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Write pin group after two flops
   logic [WSYNC_W-1:0] wr_sync;
   // Read pin group after two flops
   logic [RSYNC_W-1:0] rd_sync;
   // Settled write request
   line_buffer_pkg::wr_req_t wr_req;
   // Settled read request
   line_buffer_pkg::rd_req_t rd_req;
   // Settled port clocks and their previous values
   logic wclk_s;
   logic rclk_s;
   logic wclk_d;
   logic rclk_d;

   port_sync #(.WIDTH(WSYNC_W), .INIT({WSYNC_W{1'b1}})) u_wr_sync
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .raw_i({input_clock_i, input_pointer_clear_n_i, input_port_enable_n_i, byte_in_i}),
      .sync_o(wr_sync)
   );

   port_sync #(.WIDTH(RSYNC_W), .INIT({RSYNC_W{1'b1}})) u_rd_sync
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .raw_i({output_clock_i, output_pointer_clear_n_i, output_port_enable_n_i}),
      .sync_o(rd_sync)
   );

   assign wclk_s = wr_sync[WSYNC_W-1];
   assign wr_req = wr_sync[WSYNC_W-2:0];
   assign rclk_s = rd_sync[RSYNC_W-1];
   assign rd_req = rd_sync[RSYNC_W-2:0];

   ////////////////////////////////////////////////////////////////////////
   // Edge history of the settled port clocks
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wclk_d <= 1'b1;
         rclk_d <= 1'b1;
      end
      else
      begin
         wclk_d <= wclk_s;
         rclk_d <= rclk_s;
      end
   end

   // Port clock edges and events
   logic w_rise;
   logic w_fall;
   logic r_rise;
   logic r_fall;
   assign w_rise = wclk_s & ~wclk_d;
   assign w_fall = ~wclk_s & wclk_d;
   assign r_rise = rclk_s & ~rclk_d;
   assign r_fall = ~rclk_s & rclk_d;

   // Clear sampled on each port's own rising edge
   logic w_clear;
   logic r_clear;
   assign w_clear = w_rise & ~wr_req.clear_n; // R1 R2
   assign r_clear = r_rise & ~rd_req.clear_n; // R1 R2

   // Transfer on the rising edge while enabled and not clearing
   logic w_xfer;
   logic r_xfer;
   assign w_xfer = w_rise & ~wr_req.enable_n & wr_req.clear_n; // R6
   assign r_xfer = r_rise & ~rd_req.enable_n & rd_req.clear_n; // R7

   // Pending advance, taken on the falling edge after a transfer
   logic w_pend;
   logic r_pend;
   logic w_adv;
   logic r_adv;
   assign w_adv = w_fall & w_pend; // R20
   assign r_adv = r_fall & r_pend; // R20

   ////////////////////////////////////////////////////////////////////////
   // Advance-pending flags, one per port
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         w_pend <= 1'b0;
         r_pend <= 1'b0;
      end
      else
      begin
         // Set on transfer, consumed on falling edge
         if (w_clear)
            w_pend <= 1'b0;
         else if (w_xfer)
            w_pend <= 1'b1;
         else if (w_adv)
            w_pend <= 1'b0;
         if (r_clear)
            r_pend <= 1'b0;
         else if (r_xfer)
            r_pend <= 1'b1;
         else if (r_adv)
            r_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Linear pointers, kept for wrap detection
   logic [line_buffer_pkg::PTR_W-1:0] wr_ptr;
   logic [line_buffer_pkg::PTR_W-1:0] rd_ptr;

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_ptr <= line_buffer_pkg::PTR_ZERO;
         rd_ptr <= line_buffer_pkg::PTR_ZERO;
      end
      else
      begin
         // Each port moves on its own events only
         if (w_clear)
            wr_ptr <= line_buffer_pkg::PTR_ZERO; // R1
         else if (w_adv)
            wr_ptr <= next_ptr_f(wr_ptr); // R3 R9
         if (r_clear)
            rd_ptr <= line_buffer_pkg::PTR_ZERO; // R1
         else if (r_adv)
            rd_ptr <= next_ptr_f(rd_ptr); // R3 R9
      end
   end

   // Ring outputs, one driver each, folded into the position carriers
   logic [line_buffer_pkg::ROW_COLS-1:0] w_col_hot;
   logic [line_buffer_pkg::ROW_COLS-1:0] r_col_hot;
   logic [line_buffer_pkg::SUB_ROWS-1:0] w_row_hot;
   logic [line_buffer_pkg::SUB_ROWS-1:0] r_row_hot;
   // Selector positions derived from the pointers
   line_buffer_pkg::sel_pos_t wpos;
   line_buffer_pkg::sel_pos_t rpos;
   assign wpos = pos_f(wr_ptr, w_col_hot, w_row_hot);
   assign rpos = pos_f(rd_ptr, r_col_hot, r_row_hot);
   // Wrap back to zero behaves like a clear for the selectors
   logic w_sel_clr;
   logic r_sel_clr;
   assign w_sel_clr = w_clear | (w_adv & (next_ptr_f(wr_ptr) == line_buffer_pkg::PTR_ZERO));
   assign r_sel_clr = r_clear | (r_adv & (next_ptr_f(rd_ptr) == line_buffer_pkg::PTR_ZERO));

   // Column steps only once the static bytes are passed
   logic w_col_step;
   logic r_col_step;
   assign w_col_step = w_adv & ~wpos.in_static; // R13 R17
   assign r_col_step = r_adv & ~rpos.in_static; // R13 R17

   // Crossing pulse: last column of a subarray leaves it
   logic w_cross;
   logic r_cross;
   assign w_cross = w_col_step & wpos.col_hot[line_buffer_pkg::ROW_COLS-1];
   assign r_cross = r_col_step & rpos.col_hot[line_buffer_pkg::ROW_COLS-1];

   ////////////////////////////////////////////////////////////////////////
   // Column and row ring selectors for each port (R15)

   // Column ring, write path
   ring_selector #(.N(line_buffer_pkg::ROW_COLS)) u_wcol
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(w_sel_clr),
      .step_i(w_col_step),
      .hot_o(w_col_hot)
   );

   // Row ring, write path; steps when leaving subarray 2, so the next
   // subarray 1 row is selected before its first byte is accessed
   ring_selector #(.N(line_buffer_pkg::SUB_ROWS)) u_wrow
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(w_sel_clr),
      .step_i(w_cross & wpos.bank), // R14 R18
      .hot_o(w_row_hot)
   );

   // Column ring, read path
   ring_selector #(.N(line_buffer_pkg::ROW_COLS)) u_rcol
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(r_sel_clr),
      .step_i(r_col_step),
      .hot_o(r_col_hot)
   );

   // Row ring, read path
   ring_selector #(.N(line_buffer_pkg::SUB_ROWS)) u_rrow // R15
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .clear_i(r_sel_clr),
      .step_i(r_cross & rpos.bank), // R14 R18
      .hot_o(r_row_hot)
   );

   ////////////////////////////////////////////////////////////////////////
   // Storage: static front region and two dynamic subarrays (R8 R10)
   logic [line_buffer_pkg::BYTE_W-1:0] static_mem [line_buffer_pkg::STATIC_BYTES]; // R8
   logic [line_buffer_pkg::BYTE_W-1:0] sub1_mem [line_buffer_pkg::SUB_BYTES]; // R10
   logic [line_buffer_pkg::BYTE_W-1:0] sub2_mem [line_buffer_pkg::SUB_BYTES]; // R10

   // Byte offset inside a subarray from the row and column selects
   logic [$clog2(line_buffer_pkg::SUB_BYTES)-1:0] w_off;
   logic [$clog2(line_buffer_pkg::SUB_BYTES)-1:0] r_off;
   assign w_off = {row_idx_f(wpos.row_hot), col_idx_f(wpos.col_hot)}; // R19
   assign r_off = {row_idx_f(rpos.row_hot), col_idx_f(rpos.col_hot)};

   ////////////////////////////////////////////////////////////////////////
   // Write: only the byte at the selected row and column changes
   always_ff @(posedge core_clk_i)
   begin
      if (w_xfer)
      begin
         if (wpos.in_static)
            static_mem[wpos.static_idx] <= wr_req.data; // R11
         else if (!wpos.bank)
            sub1_mem[w_off] <= wr_req.data; // R12 R19
         else
            sub2_mem[w_off] <= wr_req.data; // R12 R19
      end
   end

   // Byte at the read selection
   logic [line_buffer_pkg::BYTE_W-1:0] rd_byte;
   always_comb
   begin
      if (rpos.in_static)
         rd_byte = static_mem[rpos.static_idx];
      else if (!rpos.bank)
         rd_byte = sub1_mem[r_off]; // R14
      else
         rd_byte = sub2_mem[r_off]; // R14
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and output drive
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         byte_out_o <= '0;
         byte_out_oe_o <= 1'b0;
      end
      else
      begin
         // Drive only while the read enable is low
         byte_out_oe_o <= ~rd_req.enable_n; // R7
         if (r_xfer)
            byte_out_o <= rd_byte; // R3
      end
   end

endmodule : serial_line_delay_buffer

// *** dv/line_buffer_properties.sv ***
// Port-level assertions for the serial line delay buffer
`timescale 1ns/100ps
module line_buffer_properties #(
   parameter bit LONG_LINE = 1'b0
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Write port pins
   input wire logic input_clock_i,
   input wire logic input_pointer_clear_n_i,
   input wire logic input_port_enable_n_i,
   input wire logic [line_buffer_pkg::BYTE_W-1:0] byte_in_i,
   // Read port pins
   input wire logic output_clock_i,
   input wire logic output_pointer_clear_n_i,
   input wire logic output_port_enable_n_i,
   // Read data and its drive enable
   input wire logic [line_buffer_pkg::BYTE_W-1:0] byte_out_o,
   input wire logic byte_out_oe_o
);
   // All checks run on the core clock and sleep in reset
   default clocking chk_clk @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Drive enable follows the output enable pin
   oe_rise_cause_a: assert property (
      $rose(byte_out_oe_o) |-> !$past(output_port_enable_n_i, 3))
      else $error("Drive enable rose without a low output enable");
   oe_fall_cause_a: assert property (
      $fell(byte_out_oe_o) |-> $past(output_port_enable_n_i, 3))
      else $error("Drive enable fell without a high output enable");
   oe_on_a: assert property (
      !output_port_enable_n_i [*6] |-> byte_out_oe_o)
      else $error("Outputs not driven while enabled");
   oe_off_a: assert property (
      output_port_enable_n_i [*6] |-> !byte_out_oe_o)
      else $error("Outputs still driven while disabled");

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read data moves only on an enabled, non-clearing output clock rise
   data_needs_oe_a: assert property (
      $changed(byte_out_o) |-> byte_out_oe_o)
      else $error("Read data changed while outputs released");
   read_on_rise_a: assert property (
      $changed(byte_out_o) |-> $past(output_clock_i, 2) || $past(output_clock_i, 3))
      else $error("Read data changed away from an output clock rise");
   no_read_off_a: assert property (
      output_port_enable_n_i [*8] |-> $stable(byte_out_o))
      else $error("Read data changed with output enable high");
   clear_no_read_a: assert property (
      !output_pointer_clear_n_i [*8] |-> $stable(byte_out_o))
      else $error("Read data changed during a pointer clear");
endmodule : line_buffer_properties

bind serial_line_delay_buffer line_buffer_properties #(.LONG_LINE(LONG_LINE)) line_buffer_properties_i (
   .core_clk_i(core_clk_i),
   .rstn_i(rstn_i),
   .input_clock_i(input_clock_i),
   .input_pointer_clear_n_i(input_pointer_clear_n_i),
   .input_port_enable_n_i(input_port_enable_n_i),
   .byte_in_i(byte_in_i),
   .output_clock_i(output_clock_i),
   .output_pointer_clear_n_i(output_pointer_clear_n_i),
   .output_port_enable_n_i(output_port_enable_n_i),
   .byte_out_o(byte_out_o),
   .byte_out_oe_o(byte_out_oe_o)
);

// *** dv/video_port_model.sv ***
// Behavioural video logic driving both ports of the line buffer
`timescale 1ns/100ps
module video_port_model
(
   // Core clock that paces the port pins
   input wire logic core_clk_i,
   // Write port pins
   output logic input_clock_o,
   output logic input_pointer_clear_n_o,
   output logic input_port_enable_n_o,
   output logic [line_buffer_pkg::BYTE_W-1:0] byte_in_o,
   // Read port pins
   output logic output_clock_o,
   output logic output_pointer_clear_n_o,
   output logic output_port_enable_n_o
);
   // Idle levels: clocks low, clears and enables inactive
   initial
   begin
      input_clock_o = 1'b0;
      input_pointer_clear_n_o = 1'b1;
      input_port_enable_n_o = 1'b1;
      byte_in_o = 8'h00;
      output_clock_o = 1'b0;
      output_pointer_clear_n_o = 1'b1;
      output_port_enable_n_o = 1'b1;
   end

   // Let n core edges pass, then move just after the last one
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step

   // One write clock; controls and data held across the rise
   task automatic write_cycle(input logic [7:0] d, input logic en_n, input logic clr_n);
      input_pointer_clear_n_o = clr_n;
      input_port_enable_n_o = en_n;
      byte_in_o = d;
      step(4);
      input_clock_o = 1'b1;
      step(4);
      input_clock_o = 1'b0;
      // Hold time over: the data line no longer shows the byte
      byte_in_o = ~d;
      step(1);
   endtask : write_cycle

   // One read clock; long high phase leaves room for the answer
   task automatic read_cycle(input logic en_n, input logic clr_n);
      output_pointer_clear_n_o = clr_n;
      output_port_enable_n_o = en_n;
      step(4);
      output_clock_o = 1'b1;
      step(6);
      output_clock_o = 1'b0;
      step(1);
   endtask : read_cycle
endmodule : video_port_model

// *** dv/serial_line_delay_buffer_tb_top.sv ***
// Self-checking bench for the line buffer in both line lengths
`timescale 1ns/100ps
module serial_line_delay_buffer_tb_top;
   // Clock, reset and counters
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   int error_cnt = 0;
   int checks_done = 0;
   // Port pins shared by both buffers
   logic wr_clk, wr_clr_n, wr_en_n, rd_clk, rd_clr_n, rd_en_n;
   logic [7:0] wr_data, out_short, out_long;
   logic oe_short, oe_long;
   // Line lengths and fill length past the longer wrap
   localparam int LEN_S = int'(line_buffer_pkg::LEN_SHORT);
   localparam int LEN_L = int'(line_buffer_pkg::LEN_LONG);
   localparam int FILL_N = LEN_L + 2;

   // Core clock at 250 MHz
   always #2 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Far-side logic and the two buffer configurations
   video_port_model video_port_model_i (.core_clk_i(core_clk), .input_clock_o(wr_clk),
      .input_pointer_clear_n_o(wr_clr_n), .input_port_enable_n_o(wr_en_n),
      .byte_in_o(wr_data), .output_clock_o(rd_clk), .output_pointer_clear_n_o(rd_clr_n),
      .output_port_enable_n_o(rd_en_n));
   serial_line_delay_buffer #(.LONG_LINE(1'b0)) serial_line_delay_buffer_i (
      .core_clk_i(core_clk), .rstn_i(rstn), .input_clock_i(wr_clk),
      .input_pointer_clear_n_i(wr_clr_n), .input_port_enable_n_i(wr_en_n),
      .byte_in_i(wr_data), .output_clock_i(rd_clk), .output_pointer_clear_n_i(rd_clr_n),
      .output_port_enable_n_i(rd_en_n), .byte_out_o(out_short), .byte_out_oe_o(oe_short));
   serial_line_delay_buffer #(.LONG_LINE(1'b1)) serial_line_delay_buffer_long_i (
      .core_clk_i(core_clk), .rstn_i(rstn), .input_clock_i(wr_clk),
      .input_pointer_clear_n_i(wr_clr_n), .input_port_enable_n_i(wr_en_n),
      .byte_in_i(wr_data), .output_clock_i(rd_clk), .output_pointer_clear_n_i(rd_clr_n),
      .output_port_enable_n_i(rd_en_n), .byte_out_o(out_long), .byte_out_oe_o(oe_long));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Compare helpers and expected data
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check_byte

   task automatic check_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   // Byte written as the i-th word of a stream
   function automatic logic [7:0] pat(input int i);
      return 8'(i) ^ 8'(i >> 3) ^ 8'h3c;
   endfunction : pat

   // Index of the last of n writes that landed at address a
   function automatic int last_idx(input int a, input int n, input int len);
      return a + len * ((n - 1 - a) / len);
   endfunction : last_idx

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic reset_state();
      check_bit("short drive", 1'b0, oe_short);
      check_bit("long drive", 1'b0, oe_long);
   endtask : reset_state

   // Write past both wraps, then read FILL_N bytes back, once past both wraps
   task automatic wrap_fill();
      video_port_model_i.write_cycle(8'h00, 1'b0, 1'b0);
      for (int i = 0; i < FILL_N; i++)
         video_port_model_i.write_cycle(pat(i), 1'b0, 1'b1);
      video_port_model_i.read_cycle(1'b0, 1'b0);
      for (int k = 0; k < FILL_N; k++)
      begin
         video_port_model_i.read_cycle(1'b0, 1'b1);
         check_byte("short line", pat(last_idx(k % LEN_S, FILL_N, LEN_S)), out_short);
         check_byte("long line", pat(last_idx(k % LEN_L, FILL_N, LEN_L)), out_long);
      end
   endtask : wrap_fill

   // Both ports at once, at different rates, read trailing write
   task automatic concurrent_stream();
      fork
         begin
            video_port_model_i.write_cycle(8'h00, 1'b0, 1'b0);
            for (int i = 0; i < 40; i++)
               video_port_model_i.write_cycle(~pat(i), 1'b0, 1'b1);
         end
         begin
            video_port_model_i.read_cycle(1'b0, 1'b0);
            video_port_model_i.step(100);
            for (int k = 0; k < 30; k++)
            begin
               video_port_model_i.read_cycle(1'b0, 1'b1);
               check_byte("short stream", ~pat(k), out_short);
               check_byte("long stream", ~pat(k), out_long);
            end
         end
      join
   endtask : concurrent_stream

   // Disabled cycles on each port leave the pointers where they were
   task automatic enable_gating();
      video_port_model_i.write_cycle(8'h00, 1'b0, 1'b0);
      video_port_model_i.write_cycle(8'ha1, 1'b0, 1'b1);
      video_port_model_i.write_cycle(8'hb2, 1'b0, 1'b1);
      video_port_model_i.write_cycle(8'hee, 1'b1, 1'b1);
      video_port_model_i.write_cycle(8'hc3, 1'b0, 1'b1);
      video_port_model_i.read_cycle(1'b0, 1'b0);
      video_port_model_i.read_cycle(1'b0, 1'b1);
      check_byte("first after clear", 8'ha1, out_short);
      video_port_model_i.read_cycle(1'b0, 1'b1);
      video_port_model_i.read_cycle(1'b1, 1'b1);
      check_bit("drive off", 1'b0, oe_short);
      check_byte("held data", 8'hb2, out_long);
      video_port_model_i.read_cycle(1'b0, 1'b1);
      check_bit("drive on", 1'b1, oe_long);
      check_byte("skipped store", 8'hc3, out_short);
      video_port_model_i.read_cycle(1'b0, 1'b1);
      check_byte("next address", ~pat(3), out_long);
   endtask : enable_gating

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic report_and_stop();
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // Main sequence: two cycles of reset, then the scenarios
   initial
   begin
      repeat (2) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      video_port_model_i.step(4);
      reset_state();
      wrap_fill();
      concurrent_stream();
      enable_gating();
      report_and_stop();
   end

   // Watchdog well beyond the expected run of about 23300 cycles
   initial
   begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      $display("Error watchdog expected done seen hang");
      report_and_stop();
   end
endmodule : serial_line_delay_buffer_tb_top
